//--- src/obc_pkg.sv
// Purpose: constants and types shared by the option byte decoder
// Assumes: option bytes arrive as a stream of byte index and value after reset
// Notes: bit positions within each option byte are fixed here
package obc_pkg;

  // ------------------------------------------------------------
  // register indices on the plain software port
  // ------------------------------------------------------------
  localparam logic [3:0] OBC_IDX_BOOT = 4'h0;
  localparam logic [3:0] OBC_IDX_ROP = 4'h1;
  localparam logic [3:0] OBC_IDX_CLOCK_WATCHDOG_OPTIONS = 4'h2;
  localparam logic [3:0] OBC_IDX_OSCILLATOR_WAKEUP_OPTIONS = 4'h3;
  localparam logic [3:0] OBC_IDX_CRYSTAL_SETTLE_COUNT = 4'h4;
  localparam logic [3:0] OBC_IDX_RESERVED_OPTION = 4'h5;
  localparam logic [3:0] OBC_IDX_FLASH_READ_DELAY_OPTION = 4'h6;
  localparam logic [3:0] OBC_IDX_STATUS = 4'h7;
  localparam logic [3:0] OBC_IDX_ROP_REQ = 4'h8;
  localparam int OBC_NUM_BYTES = 7;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int OBC_BIT_LSI_ALLOW = 3;
  localparam int OBC_BIT_INDEP_WATCHDOG_HW_START = 2;
  localparam int OBC_BIT_WINDOW_WATCHDOG_HW_START = 1;
  localparam int OBC_BIT_WINDOW_WATCHDOG_HALT_RESET = 0;
  localparam int OBC_BIT_EXTERNAL_CLOCK_SELECT = 3;
  localparam int OBC_BIT_AWUSEL = 2;
  localparam int OBC_BIT_PRSC_LO = 0;
  localparam int OBC_BIT_WAIT = 0;
  localparam logic [7:0] OBC_ROP_ACTIVE = 8'haa;

  // ------------------------------------------------------------
  // sizes and reset values
  // ------------------------------------------------------------
  localparam int OBC_PAGE_SHIFT = 9;
  localparam logic [17:0] OBC_FLASH_BYTES = 18'h20000;
  localparam logic [7:0] OBC_RST_BYTE = 8'h00;

  // crystal settle codes and their counts in oscillator half cycles
  localparam logic [7:0] OBC_HSE_CODE_2048 = 8'h00;
  localparam logic [7:0] OBC_HSE_CODE_128 = 8'hb4;
  localparam logic [7:0] OBC_HSE_CODE_8 = 8'hd2;
  localparam logic [7:0] OBC_HSE_CODE_HALF = 8'he1;
  localparam logic [12:0] OBC_HSE_HALF_2048 = 13'h1000;
  localparam logic [12:0] OBC_HSE_HALF_128 = 13'h0100;
  localparam logic [12:0] OBC_HSE_HALF_8 = 13'h0010;
  localparam logic [12:0] OBC_HSE_HALF_HALF = 13'h0001;

  // wakeup prescaler source frequency in MHz, output 128 kHz
  localparam int OBC_AWU_OUT_KHZ = 128;

  typedef enum logic [1:0] {
    OBC_ST_LOAD,
    OBC_ST_RUN,
    OBC_ST_ERASE
  } obc_state_t;

endpackage

//--- src/obc_dec_if.sv
// Purpose: carries captured option bytes from the loader to the decoder
// Assumes: one clock
// Notes: loader writes, decoder reads
`timescale 1ns/1ns
`default_nettype none
interface obc_dec_if;
  logic [7:0] clock_watchdog_options;
  logic [7:0] oscillator_wakeup_options;
  logic [7:0] crystal_settle_count;
  logic [7:0] flash_read_delay_option;
  logic [7:0] boot;
  modport src (output clock_watchdog_options, output oscillator_wakeup_options, output crystal_settle_count, output flash_read_delay_option, output boot);
  modport dst (input clock_watchdog_options, input oscillator_wakeup_options, input crystal_settle_count, input flash_read_delay_option, input boot);
endinterface
`default_nettype wire

//--- src/obc_decode.sv
// Purpose: pure decode of captured option bytes
// Assumes: inputs stable between resets
// Notes: combinational, outputs are registered by the top
`timescale 1ns/1ns
`default_nettype none
module obc_decode
  import obc_pkg::*;
(
  obc_dec_if.dst opts,
  output logic [17:0] boot_bytes,
  output logic [12:0] settle_half,
  output logic [4:0] awu_src_mhz
);

  always_comb begin
    boot_bytes = {opts.boot, {OBC_PAGE_SHIFT{1'b0}}} > 17'h1ffff ?
                 OBC_FLASH_BYTES : {1'b0, opts.boot, {OBC_PAGE_SHIFT{1'b0}}};
    case (opts.crystal_settle_count)
      OBC_HSE_CODE_2048: settle_half = OBC_HSE_HALF_2048;
      OBC_HSE_CODE_128: settle_half = OBC_HSE_HALF_128;
      OBC_HSE_CODE_8: settle_half = OBC_HSE_HALF_8;
      OBC_HSE_CODE_HALF: settle_half = OBC_HSE_HALF_HALF;
      default: settle_half = OBC_HSE_HALF_2048;
    endcase
    case (opts.oscillator_wakeup_options[OBC_BIT_PRSC_LO +: 2])
      2'b00: awu_src_mhz = 5'd24;
      2'b01: awu_src_mhz = 5'd16;
      2'b10: awu_src_mhz = 5'd8;
      default: awu_src_mhz = 5'd4;
    endcase
  end

endmodule
`default_nettype wire

//--- src/obc_top.sv
// Purpose: loads option bytes after reset and drives configuration outputs
// Assumes: option storage answers one byte per cycle after a request
// Notes: configuration outputs are fixed from the end of loading until the next reset
//
// Overview of operation
// - Boot area size is the option byte times 512 bytes.
// - Boot area stays write protected whenever programmed from application code.
// - Active readout protection refuses debug-path flash and EEPROM access.
// - Changing active readout protection erases program and data memory.
// - Low-speed oscillator allowed as CPU clock only when option is 1.
// - Independent watchdog starts by hardware when option is 1.
// - Window watchdog starts by hardware when option is 1.
// - Halt resets with window watchdog active only when option is 1.
// - Option 1 selects external clock input, 0 selects crystal.
// - Wakeup clock from low-speed oscillator at 0, prescaled crystal at 1.
// - Prescaler code picks 24, 16, 8 or 4 MHz source to 128 kHz.
// - Settle code picks 2048, 128, 8 or half crystal cycles.
// - Flash read delay option adds exactly one wait state when 1.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module obc_top
  import obc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  output logic [2:0] nvm_idx,
  output logic nvm_rd,
  input wire logic [7:0] nvm_data,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic iap_write_req,
  input wire logic [16:0] iap_write_addr,
  input wire logic dbg_access_req,
  output logic iap_write_ok,
  output logic dbg_access_ok,
  output logic global_erase,
  output logic cfg_valid,
  output logic [17:0] boot_area_bytes,
  output logic low_speed_osc_allow,
  output logic indep_watchdog_hw_start,
  output logic window_watchdog_hw_start,
  output logic window_watchdog_halt_reset,
  output logic external_clock_select,
  output logic wakeup_clock_select,
  output logic [1:0] wakeup_prescaler,
  output logic [4:0] wakeup_src_mhz,
  output logic [12:0] crystal_settle_half,
  output logic flash_read_delay
);
  import obc_pkg::*;

  // ------------------------------------------------------------
  // load sequencer
  // ------------------------------------------------------------
  obc_state_t state_q, state_d;
  logic [7:0] byte_q [OBC_NUM_BYTES];
  logic [7:0] byte_d [OBC_NUM_BYTES];
  logic [2:0] idx_q, idx_d;
  logic rd_pend_q, rd_pend_d;
  logic [2:0] rd_idx_q, rd_idx_d;
  logic rop_req_q, rop_req_d;
  logic [7:0] rdata_d;
  logic rop_active;
  logic [17:0] boot_w;
  logic [12:0] settle_w;
  logic [4:0] awu_w;
  obc_dec_if dec_if ();

  function automatic logic bit_of(input logic [7:0] b, input int pos);
    bit_of = b[pos[2:0]];
  endfunction

  assign rop_active = (byte_q[OBC_IDX_ROP[2:0]] == OBC_ROP_ACTIVE);
  assign dec_if.boot = byte_q[OBC_IDX_BOOT[2:0]];
  assign dec_if.clock_watchdog_options = byte_q[OBC_IDX_CLOCK_WATCHDOG_OPTIONS[2:0]];
  assign dec_if.oscillator_wakeup_options = byte_q[OBC_IDX_OSCILLATOR_WAKEUP_OPTIONS[2:0]];
  assign dec_if.crystal_settle_count = byte_q[OBC_IDX_CRYSTAL_SETTLE_COUNT[2:0]];
  assign dec_if.flash_read_delay_option = byte_q[OBC_IDX_FLASH_READ_DELAY_OPTION[2:0]];

  obc_decode u_dec (
    .opts(dec_if.dst),
    .boot_bytes(boot_w),
    .settle_half(settle_w),
    .awu_src_mhz(awu_w)
  );

  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    rd_pend_d = 1'b0;
    rd_idx_d = idx_q;
    byte_d = byte_q;
    rop_req_d = rop_req_q;
    // read every byte once after reset
    case (state_q)
      OBC_ST_LOAD: begin
        if (rd_pend_q) begin
          byte_d[rd_idx_q] = nvm_data;
        end
        if (idx_q < 3'(OBC_NUM_BYTES)) begin
          rd_pend_d = 1'b1;
          idx_d = idx_q + 3'd1;
        end else if (!rd_pend_q) begin
          state_d = OBC_ST_RUN;
        end
      end
      OBC_ST_RUN: begin
        if (reg_wr && reg_addr == OBC_IDX_ROP_REQ) begin
          rop_req_d = 1'b1;
          if (rop_active && reg_wdata != OBC_ROP_ACTIVE) begin
            state_d = OBC_ST_ERASE;
          end
        end
      end
      OBC_ST_ERASE: begin
        state_d = OBC_ST_ERASE;
      end
      default: state_d = OBC_ST_LOAD;
    endcase
  end

  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      if (reg_addr < 4'(OBC_NUM_BYTES)) begin
        rdata_d = byte_q[reg_addr[2:0]];
      end else if (reg_addr == OBC_IDX_STATUS) begin
        rdata_d = {5'h00, state_q == OBC_ST_ERASE, rop_active, state_q != OBC_ST_LOAD};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= OBC_ST_LOAD;
      idx_q <= 3'd0;
      rd_pend_q <= 1'b0;
      rd_idx_q <= 3'd0;
      rop_req_q <= 1'b0;
      for (int i = 0; i < OBC_NUM_BYTES; i++) begin
        byte_q[i] <= OBC_RST_BYTE;
      end
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      rd_pend_q <= rd_pend_d;
      rd_idx_q <= rd_idx_d;
      rop_req_q <= rop_req_d;
      byte_q <= byte_d;
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  logic run_d;
  logic iap_ok_d;
  logic dbg_ok_d;
  assign run_d = (state_d == OBC_ST_RUN);
  // boot area never writable from application
  assign iap_ok_d = run_d && iap_write_req && ({1'b0, iap_write_addr} >= boot_w);
  assign dbg_ok_d = run_d && dbg_access_req && !rop_active;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      nvm_idx <= 3'd0;
      nvm_rd <= 1'b0;
      reg_rdata <= 8'h00;
      iap_write_ok <= 1'b0;
      dbg_access_ok <= 1'b0;
      global_erase <= 1'b0;
      cfg_valid <= 1'b0;
      boot_area_bytes <= 18'h00000;
      low_speed_osc_allow <= 1'b0;
      indep_watchdog_hw_start <= 1'b0;
      window_watchdog_hw_start <= 1'b0;
      window_watchdog_halt_reset <= 1'b0;
      external_clock_select <= 1'b0;
      wakeup_clock_select <= 1'b0;
      wakeup_prescaler <= 2'b00;
      wakeup_src_mhz <= 5'd0;
      crystal_settle_half <= 13'h0000;
      flash_read_delay <= 1'b0;
    end else begin
      nvm_idx <= idx_q;
      nvm_rd <= rd_pend_d;
      reg_rdata <= rdata_d;
      iap_write_ok <= iap_ok_d;
      dbg_access_ok <= dbg_ok_d;
      global_erase <= (state_d == OBC_ST_ERASE);
      cfg_valid <= (state_d != OBC_ST_LOAD);
      boot_area_bytes <= boot_w;
      low_speed_osc_allow <= bit_of(dec_if.clock_watchdog_options, OBC_BIT_LSI_ALLOW);
      indep_watchdog_hw_start <= bit_of(dec_if.clock_watchdog_options, OBC_BIT_INDEP_WATCHDOG_HW_START);
      window_watchdog_hw_start <= bit_of(dec_if.clock_watchdog_options, OBC_BIT_WINDOW_WATCHDOG_HW_START);
      window_watchdog_halt_reset <= bit_of(dec_if.clock_watchdog_options, OBC_BIT_WINDOW_WATCHDOG_HALT_RESET);
      external_clock_select <= bit_of(dec_if.oscillator_wakeup_options, OBC_BIT_EXTERNAL_CLOCK_SELECT);
      wakeup_clock_select <= bit_of(dec_if.oscillator_wakeup_options, OBC_BIT_AWUSEL);
      wakeup_prescaler <= dec_if.oscillator_wakeup_options[OBC_BIT_PRSC_LO +: 2];
      wakeup_src_mhz <= awu_w;
      crystal_settle_half <= settle_w;
      flash_read_delay <= bit_of(dec_if.flash_read_delay_option, OBC_BIT_WAIT);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_DBG_BLOCK: assert property (@(posedge clk_sys) disable iff (rst)
    rop_active |=> !dbg_access_ok) else $error("debug access granted under protection");
  AST_BOOT_WP: assert property (@(posedge clk_sys) disable iff (rst)
    (iap_write_req && {1'b0, iap_write_addr} < boot_w) |=> !iap_write_ok)
    else $error("boot area write allowed");
  AST_ERASE: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == OBC_ST_RUN && rop_active && reg_wr && reg_addr == OBC_IDX_ROP_REQ
     && reg_wdata != OBC_ROP_ACTIVE) |=> global_erase[*2]) else $error("no erase on toggle");
  AST_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    (cfg_valid && $past(cfg_valid)) |-> $stable(flash_read_delay) && $stable(boot_area_bytes))
    else $error("config changed after load");
  AST_WAIT: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_valid |-> flash_read_delay == dec_if.flash_read_delay_option[OBC_BIT_WAIT]) else $error("wait state wrong");
  AST_LOAD_END: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(nvm_rd) |-> ##[1:20] cfg_valid) else $error("load did not finish");
  AST_WINDOW_WATCHDOG: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_valid |-> window_watchdog_halt_reset == dec_if.clock_watchdog_options[OBC_BIT_WINDOW_WATCHDOG_HALT_RESET])
    else $error("halt reset option wrong");
  AST_BOOT_SIZE: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_valid && dec_if.boot == 8'h01 |-> boot_area_bytes == 18'h00200)
    else $error("boot page size wrong");

endmodule
`default_nettype wire

//--- testbench/obc_nvm_model.sv
// Purpose: option storage model answering byte reads from the decoder
// Assumes: read request and index registered by the decoder, one byte per cycle
// Notes: the byte stands while the request is high; otherwise the bus toggles
`timescale 1ns/1ns
`default_nettype none
module obc_nvm_model (
  input wire logic clk_sys,
  input wire logic [2:0] nvm_idx,
  input wire logic nvm_rd,
  input wire logic [55:0] image,
  output logic [7:0] nvm_data
);
  logic [7:0] junk_q;
  initial junk_q = 8'h5a;
  // -----------------------------------------------
  // answer in the request cycle, else toggle
  // -----------------------------------------------
  // decoder captures the byte at the edge that ends its request cycle
  always @(posedge clk_sys) begin
    junk_q <= ~junk_q;
  end
  assign nvm_data = nvm_rd ? image[nvm_idx * 8 +: 8] : junk_q;
endmodule
`default_nettype wire

//--- testbench/option_byte_config_decoder_test.sv
// Purpose: self-checking bench for the option byte decoder
// Assumes: storage model on the option read port, plain register port
// Notes: each row reloads the options through a fresh reset
`timescale 1ns/1ns
`default_nettype none
module option_byte_config_decoder_test;
  import obc_pkg::*;
  typedef struct {
    logic [7:0] boot, readout_protection, o3, o4, o5, o7;
    logic [4:0] mhz;
    logic [12:0] half;
  } obc_row_t;
  logic clk_sys = 1'b0, rst = 1'b1, nvm_rd, reg_wr = 1'b0, reg_rd = 1'b0;
  logic iap_write_req = 1'b0, dbg_access_req = 1'b0, iap_write_ok, dbg_access_ok;
  logic global_erase, cfg_valid, low_speed_internal_osc, independent_watchdog, window_watchdog, halt, extc, awus, frd;
  logic [2:0] nvm_idx;
  logic [7:0] nvm_data, reg_rdata, rd_v, reg_wdata = 8'h00;
  logic [3:0] reg_addr = 4'h0;
  logic [16:0] iap_write_addr = 17'h0;
  logic [17:0] boot_area_bytes;
  logic [1:0] prsc;
  logic [4:0] mhz;
  logic [12:0] half;
  logic [55:0] image = '0;
  int bad_count = 0, cmp_count = 0;
  // rows with a 24 or 8 MHz source ask for the read wait state
  obc_row_t rows [4] = '{
    '{8'h04, 8'h00, 8'h0f, 8'h0c, 8'h00, 8'h01, 5'd24, 13'h1000},
    '{8'h00, 8'h00, 8'h00, 8'h01, 8'hb4, 8'h00, 5'd16, 13'h0100},
    '{8'hff, 8'h00, 8'h05, 8'h06, 8'hd2, 8'h01, 5'd8, 13'h0010},
    '{8'h01, 8'h00, 8'h0a, 8'h0b, 8'he1, 8'h00, 5'd4, 13'h0001}};
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  obc_nvm_model model (.clk_sys(clk_sys), .nvm_idx(nvm_idx), .nvm_rd(nvm_rd),
    .image(image), .nvm_data(nvm_data));
  obc_top dut (.clk_sys(clk_sys), .rst(rst), .nvm_idx(nvm_idx), .nvm_rd(nvm_rd),
    .nvm_data(nvm_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .iap_write_req(iap_write_req),
    .iap_write_addr(iap_write_addr), .dbg_access_req(dbg_access_req),
    .iap_write_ok(iap_write_ok), .dbg_access_ok(dbg_access_ok),
    .global_erase(global_erase), .cfg_valid(cfg_valid), .boot_area_bytes(boot_area_bytes),
    .low_speed_osc_allow(low_speed_internal_osc), .indep_watchdog_hw_start(independent_watchdog),
    .window_watchdog_hw_start(window_watchdog), .window_watchdog_halt_reset(halt),
    .external_clock_select(extc), .wakeup_clock_select(awus), .wakeup_prescaler(prsc),
    .wakeup_src_mhz(mhz), .crystal_settle_half(half), .flash_read_delay(frd));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic load(input obc_row_t r);
    int n;
    image <= {r.o7, 8'h3c, r.o5, r.o4, r.o3, r.readout_protection, r.boot};
    rst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    #1;
    chk({cfg_valid, boot_area_bytes}, 19'h0);
    rst <= 1'b0;
    n = 0;
    while (cfg_valid !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 40) begin
      bad_count++;
      wrap_up();
    end
  endtask
  task automatic probe(input logic in_application_programming, input logic [16:0] a, input logic exp);
    @(posedge clk_sys);
    iap_write_req <= in_application_programming;
    dbg_access_req <= ~in_application_programming;
    iap_write_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(in_application_programming ? iap_write_ok : dbg_access_ok, exp);
  endtask
  initial begin
    for (int i = 0; i < 4; i++) begin
      load(rows[i]);
      chk({14'h0, boot_area_bytes}, {rows[i].boot, 9'h000});
      chk({low_speed_internal_osc, independent_watchdog, window_watchdog, halt}, rows[i].o3[3:0]);
      chk({extc, awus}, rows[i].o4[3:2]);
      chk({prsc, mhz}, {rows[i].o4[1:0], rows[i].mhz});
      chk(half, rows[i].half);
      chk(frd, rows[i].o7[0]);
      for (int k = 0; k < OBC_NUM_BYTES; k++) begin
        reg_read(k[3:0], rd_v);
        chk(rd_v, image[k * 8 +: 8]);
      end
      $display("row %0d done", i);
    end
    // storage changes after load must not reach the outputs
    image <= '1;
    reg_write(OBC_IDX_CLOCK_WATCHDOG_OPTIONS, 8'hff);
    repeat (5) @(posedge clk_sys);
    #1;
    chk({low_speed_internal_osc, independent_watchdog, window_watchdog, halt, half, boot_area_bytes}, {4'ha, 13'h0001, 18'h00200});
    reg_read(4'hf, rd_v);
    chk(rd_v, 8'h00);
    probe(1'b1, 17'h001ff, 1'b0);
    probe(1'b1, 17'h00200, 1'b1);
    probe(1'b0, 17'h0, 1'b1);
    reg_write(OBC_IDX_ROP_REQ, 8'h00);
    chk(global_erase, 1'b0);
    $display("boot area and access test done");
    load('{8'h00, OBC_ROP_ACTIVE, 8'h00, 8'h00, 8'h00, 8'h00, 5'd24, 13'h1000});
    probe(1'b0, 17'h0, 1'b0);
    reg_read(OBC_IDX_STATUS, rd_v);
    chk(rd_v[2:0], 3'b011);
    reg_write(OBC_IDX_ROP_REQ, 8'h00);
    chk(global_erase, 1'b1);
    reg_read(OBC_IDX_STATUS, rd_v);
    chk(rd_v[2], 1'b1);
    $display("protection test done");
    wrap_up();
  end
endmodule
`default_nettype wire
